/* fsf_regs.svh */
`ifndef FSF_REGS_SVH
`define FSF_REGS_SVH

// ==========================================================================
// Storage geometry
`define FSF_DATA_W      9
`define FSF_ADDR_W      14
`define FSF_PTR_W       15
`define FSF_DEPTH       15'h4000

// ==========================================================================
// Flag offsets, fixed; there is no path to program them
`define FSF_EMPTY_OFS   15'h0007
`define FSF_FULL_OFS    15'h0007

// ==========================================================================
// Reset values
`define FSF_PTR_RST     15'h0000
`define FSF_DATA_RST    9'h000

`endif

/* fsf_pkg.sv */
`include "fsf_regs.svh"

package fsf_pkg;

  typedef logic [`FSF_DATA_W-1:0] fsf_data_t;
  typedef logic [`FSF_ADDR_W-1:0] fsf_addr_t;
  typedef logic [`FSF_PTR_W-1:0]  fsf_ptr_t;

endpackage : fsf_pkg

/* fsf_mem_if.sv */
`timescale 1ns/1ns

interface fsf_mem_if;
  logic              wr_en;
  fsf_pkg::fsf_addr_t wr_addr;
  fsf_pkg::fsf_data_t wr_data;
  logic              rd_en;
  fsf_pkg::fsf_addr_t rd_addr;
  fsf_pkg::fsf_data_t rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_en, input rd_addr, output rd_data);
endinterface : fsf_mem_if

/* fsf_mem.sv */
`timescale 1ns/1ns
`include "fsf_regs.svh"

module fsf_mem (
  input  wire logic clk,
  input  wire logic rd_clk,
  input  wire logic rst_n,
  fsf_mem_if.mem    port
);

  fsf_pkg::fsf_data_t store [0:(1 << `FSF_ADDR_W)-1];
  fsf_pkg::fsf_data_t rd_data_r;

  // ==========================================================================
  // Write side
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // ==========================================================================
  // Read side, output held between reads
  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= `FSF_DATA_RST;
    end else if (port.rd_en) begin
      rd_data_r <= store[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_r;

endmodule : fsf_mem

/* fsf_top.sv */
`timescale 1ns/1ns
`include "fsf_regs.svh"

module fsf_top (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               rd_clk,
  input  wire fsf_pkg::fsf_data_t data_in,
  input  wire logic               write_enable_primary_n,
  input  wire logic               write_enable_secondary_or_load,
  input  wire logic               read_enable_primary_n,
  input  wire logic               read_enable_secondary_n,
  output fsf_pkg::fsf_data_t      data_out,
  output logic                    full_indicator_n,
  output logic                    almost_full_indicator_n,
  output logic                    empty_indicator_n,
  output logic                    almost_empty_indicator_n
);

  function automatic fsf_pkg::fsf_ptr_t bin2gray(input fsf_pkg::fsf_ptr_t b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic fsf_pkg::fsf_ptr_t gray2bin(input fsf_pkg::fsf_ptr_t g);
    fsf_pkg::fsf_ptr_t b;
    b = g;
    for (int i = `FSF_PTR_W-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  fsf_mem_if mif ();

  fsf_mem u_mem (
    .clk    (clk),
    .rd_clk (rd_clk),
    .rst_n  (rst_n),
    .port   (mif.mem)
  );

  // ==========================================================================
  // Write domain
  fsf_pkg::fsf_ptr_t wptr_r;
  fsf_pkg::fsf_ptr_t wptr_nxt;
  fsf_pkg::fsf_ptr_t wgray_r;
  fsf_pkg::fsf_ptr_t rgray_r;
  fsf_pkg::fsf_ptr_t rq1_r;
  fsf_pkg::fsf_ptr_t rq2_r;
  fsf_pkg::fsf_ptr_t rbin_w;
  fsf_pkg::fsf_ptr_t wcnt;
  logic              full_r;
  logic              afull_n_r;
  logic              wr_acc;

  assign wr_acc   = ce & ~write_enable_primary_n & write_enable_secondary_or_load
                    & ~full_r;
  assign wptr_nxt = wptr_r + {{(`FSF_PTR_W-1){1'b0}}, wr_acc};
  assign rbin_w   = gray2bin(rq2_r);
  assign wcnt     = wptr_nxt - rbin_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r  <= `FSF_PTR_RST;
      wgray_r <= `FSF_PTR_RST;
    end else if (ce) begin
      wptr_r  <= wptr_nxt;
      wgray_r <= bin2gray(wptr_nxt);
    end
  end

  // Read pointer into write domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rq1_r <= `FSF_PTR_RST;
      rq2_r <= `FSF_PTR_RST;
    end else if (ce) begin
      rq1_r <= rgray_r;
      rq2_r <= rq1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_r    <= 1'b0;
      afull_n_r <= 1'b1;
    end else if (ce) begin
      full_r    <= (wcnt == `FSF_DEPTH);
      afull_n_r <= ((`FSF_DEPTH - wcnt)
                    > `FSF_FULL_OFS);
    end
  end

  assign full_indicator_n        = ~full_r;
  assign almost_full_indicator_n = afull_n_r;

  // ==========================================================================
  // Read domain
  logic              ce_q1_r;
  logic              ce_q2_r;
  fsf_pkg::fsf_ptr_t rptr_r;
  fsf_pkg::fsf_ptr_t rptr_nxt;
  fsf_pkg::fsf_ptr_t wq1_r;
  fsf_pkg::fsf_ptr_t wq2_r;
  fsf_pkg::fsf_ptr_t wbin_r;
  fsf_pkg::fsf_ptr_t rcnt;
  logic              empty_r;
  logic              aempty_n_r;
  logic              rd_acc;

  // Enable level carried into read domain
  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_q1_r <= 1'b0;
      ce_q2_r <= 1'b0;
    end else begin
      ce_q1_r <= ce;
      ce_q2_r <= ce_q1_r;
    end
  end

  assign rd_acc   = ce_q2_r & ~read_enable_primary_n & ~read_enable_secondary_n
                    & ~empty_r;
  assign rptr_nxt = rptr_r + {{(`FSF_PTR_W-1){1'b0}}, rd_acc};
  assign wbin_r   = gray2bin(wq2_r);
  assign rcnt     = wbin_r - rptr_nxt;

  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr_r  <= `FSF_PTR_RST;
      rgray_r <= `FSF_PTR_RST;
    end else if (ce_q2_r) begin
      rptr_r  <= rptr_nxt;
      rgray_r <= bin2gray(rptr_nxt);
    end
  end

  // Write pointer into read domain
  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      wq1_r <= `FSF_PTR_RST;
      wq2_r <= `FSF_PTR_RST;
    end else if (ce_q2_r) begin
      wq1_r <= wgray_r;
      wq2_r <= wq1_r;
    end
  end

  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      empty_r    <= 1'b1;
      aempty_n_r <= 1'b0;
    end else if (ce_q2_r) begin
      empty_r    <= (rcnt == `FSF_PTR_RST);
      aempty_n_r <= (rcnt > `FSF_EMPTY_OFS);
    end
  end

  assign empty_indicator_n        = ~empty_r;
  assign almost_empty_indicator_n = aempty_n_r;

  // ==========================================================================
  // Storage connection
  assign mif.wr_en   = wr_acc;
  assign mif.wr_addr = wptr_r[`FSF_ADDR_W-1:0];
  assign mif.wr_data = data_in;
  assign mif.rd_en   = rd_acc;
  assign mif.rd_addr = rptr_r[`FSF_ADDR_W-1:0];
  assign data_out    = mif.rd_data;

  // ==========================================================================
  // Checks, write domain
  a_full_write_block: assert property (
    @(posedge clk) disable iff (!rst_n)
    !full_indicator_n |=> wptr_r == $past(wptr_r))
    else $error("write accepted while full");

  a_full_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(ce) && full_r |-> (wptr_r - $past(rbin_w)) == `FSF_DEPTH)
    else $error("full shown without full count");

  a_full_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(full_r) |-> $past(rbin_w) != $past(rbin_w, 2))
    else $error("full released without synced read");

  a_almost_full: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(ce) |-> almost_full_indicator_n ==
      ((`FSF_DEPTH - (wptr_r - $past(rbin_w))) > `FSF_FULL_OFS))
    else $error("almost full level wrong");

  a_af_default: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(ce) && (wptr_r - $past(rbin_w)) == (`FSF_DEPTH - 15'h0007)
    |-> !almost_full_indicator_n)
    else $error("almost full offset not seven");

  // ==========================================================================
  // Checks, read domain
  a_empty_read_block: assert property (
    @(posedge rd_clk) disable iff (!rst_n)
    !empty_indicator_n |=> rptr_r == $past(rptr_r))
    else $error("read accepted while empty");

  a_empty_level: assert property (
    @(posedge rd_clk) disable iff (!rst_n)
    $past(ce_q2_r) && empty_r |-> $past(wbin_r) == rptr_r)
    else $error("empty shown with words stored");

  a_empty_release: assert property (
    @(posedge rd_clk) disable iff (!rst_n)
    $fell(empty_r) |-> $past(wbin_r) != $past(wbin_r, 2))
    else $error("empty released without synced write");

  a_almost_empty: assert property (
    @(posedge rd_clk) disable iff (!rst_n)
    $past(ce_q2_r) |-> almost_empty_indicator_n ==
      (($past(wbin_r) - rptr_r) > `FSF_EMPTY_OFS))
    else $error("almost empty level wrong");

  a_dout_hold: assert property (
    @(posedge rd_clk) disable iff (!rst_n)
    !$past(rd_acc) |-> $stable(data_out))
    else $error("data output moved without read");

  c_fill_full: cover property (@(posedge clk) disable iff (!rst_n) $rose(full_r));
  c_write_blocked: cover property (@(posedge clk) disable iff (!rst_n)
    full_r && ce && !write_enable_primary_n && write_enable_secondary_or_load);
  c_drain_empty: cover property (@(posedge rd_clk) disable iff (!rst_n) $rose(empty_r));
  c_read_blocked: cover property (@(posedge rd_clk) disable iff (!rst_n)
    empty_r && !read_enable_primary_n && !read_enable_secondary_n);

endmodule : fsf_top

/* fsf_far.sv */
`timescale 1ns/1ns

// ==========================================================================
// Writer and reader logic at the far side of the buffer
module fsf_far (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                wr_go,
  input  wire logic                wr_load,
  input  wire logic                rd_go,
  output fsf_pkg::fsf_data_t       data_in,
  output logic                     write_enable_primary_n,
  output logic                     write_enable_secondary_or_load,
  output logic                     read_enable_primary_n,
  output logic                     read_enable_secondary_n
);
  fsf_pkg::fsf_data_t wcnt_r;

  // Writer attempts every cycle it is told to, full or not
  assign write_enable_primary_n         = ~wr_go;
  assign write_enable_secondary_or_load = wr_load;
  assign data_in                        = wcnt_r;
  assign read_enable_primary_n          = ~rd_go;
  assign read_enable_secondary_n        = ~rd_go;

  // Fresh data word for every attempt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_r <= 9'h0A5;
    end else if (wr_go) begin
      wcnt_r <= wcnt_r + 9'h001;
    end
  end
endmodule : fsf_far

/* tb.sv */
`timescale 1ns/1ns

module tb;
  logic               clk, rd_clk, rst_n, ce, wr_go, wr_load, rd_go;
  logic               w1_n, w2, r1_n, r2_n, f_n, af_n, e_n, ae_n;
  fsf_pkg::fsf_data_t d_in, d_out;
  int                 err_count, cmp_count, cyc;

  fsf_far far (.clk(clk), .rst_n(rst_n), .wr_go(wr_go), .wr_load(wr_load), .rd_go(rd_go),
    .data_in(d_in), .write_enable_primary_n(w1_n), .write_enable_secondary_or_load(w2),
    .read_enable_primary_n(r1_n), .read_enable_secondary_n(r2_n));
  fsf_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .rd_clk(rd_clk), .data_in(d_in),
    .write_enable_primary_n(w1_n), .write_enable_secondary_or_load(w2),
    .read_enable_primary_n(r1_n), .read_enable_secondary_n(r2_n), .data_out(d_out),
    .full_indicator_n(f_n), .almost_full_indicator_n(af_n),
    .empty_indicator_n(e_n), .almost_empty_indicator_n(ae_n));

  // ========================================================================
  // Clocks, time limit, verdict
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rd_clk = 1'b0;
    #7;
    forever #80 rd_clk = ~rd_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // ========================================================================
  // Compares and drivers
  task automatic chk_d(input string nm, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_d

  task automatic chk_f(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_f

  task automatic wr(input int n);
    @(posedge clk) wr_go <= 1'b1;
    repeat (n) @(posedge clk);
    wr_go <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input int n);
    @(posedge rd_clk) rd_go <= 1'b1;
    repeat (n) @(posedge rd_clk);
    rd_go <= 1'b0;
    #1;
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge rd_clk);
    repeat (6) @(posedge clk);
    #1;
  endtask : settle

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    chk_f("empty", 1'b0, e_n);
    chk_f("almost_empty", 1'b0, ae_n);
    chk_f("full", 1'b1, f_n);
    chk_f("almost_full", 1'b1, af_n);
    rd(2);
    chk_d("data_out", 9'h000, d_out);
  endtask : t_reset

  task automatic t_one();
    wr(1);
    chk_f("empty", 1'b0, e_n);
    settle();
    chk_f("empty", 1'b1, e_n);
    chk_f("almost_empty", 1'b0, ae_n);
    rd(1);
    chk_d("data_out", 9'h0A5, d_out);
    chk_f("empty", 1'b0, e_n);
    rd(2);
    chk_d("data_out", 9'h0A5, d_out);
  endtask : t_one

  task automatic t_almost_empty();
    wr(7);
    settle();
    chk_f("almost_empty", 1'b0, ae_n);
    wr(1);
    settle();
    chk_f("almost_empty", 1'b1, ae_n);
    rd(8);
    chk_d("data_out", 9'h0AD, d_out);
    chk_f("empty", 1'b0, e_n);
  endtask : t_almost_empty

  task automatic t_load();
    @(posedge clk) wr_load <= 1'b0;
    wr(3);
    @(posedge clk) wr_load <= 1'b1;
    settle();
    chk_f("empty", 1'b0, e_n);
  endtask : t_load

  task automatic t_hold();
    @(posedge clk) ce <= 1'b0;
    wr(2);
    @(posedge clk) ce <= 1'b1;
    settle();
    chk_f("empty", 1'b0, e_n);
    wr(1);
    settle();
    chk_f("empty", 1'b1, e_n);
    @(posedge clk) ce <= 1'b0;
    settle();
    rd(2);
    chk_f("empty", 1'b1, e_n);
    chk_d("data_out", 9'h0AD, d_out);
    @(posedge clk) ce <= 1'b1;
    settle();
    rd(1);
    chk_d("data_out", 9'h0B3, d_out);
    chk_f("empty", 1'b0, e_n);
  endtask : t_hold

  task automatic t_full();
    wr(16376);
    settle();
    chk_f("almost_full", 1'b1, af_n);
    wr(1);
    chk_f("almost_full", 1'b0, af_n);
    wr(6);
    chk_f("full", 1'b1, f_n);
    wr(1);
    chk_f("full", 1'b0, f_n);
    wr(5);
    chk_f("full", 1'b0, f_n);
    rd(1);
    chk_d("data_out", 9'h0B4, d_out);
    chk_f("full", 1'b0, f_n);
    settle();
    chk_f("full", 1'b1, f_n);
    chk_f("almost_full", 1'b0, af_n);
    rd(1);
    chk_d("data_out", 9'h0B5, d_out);
  endtask : t_full

  initial begin
    rst_n     = 1'b0;
    ce        = 1'b1;
    wr_go     = 1'b0;
    wr_load   = 1'b1;
    rd_go     = 1'b0;
    err_count = 0;
    cmp_count = 0;
    cyc       = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge rd_clk);
    #1;
    t_reset();
    t_one();
    t_almost_empty();
    t_load();
    t_hold();
    t_full();
    finish_test();
  end
endmodule : tb
